// [core/fed_escape_decoder.sv]
// escape-word decoder top: avalon slave, decode latch and counters
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - only words with 11011 in bits 15-11 count as coprocessor words
// - every accepted word falls into exactly one of five layouts
// - layout one: upper code 10-9, mode 7-6, lower code 4-3, operand 2-0
// - layout two: format 10-9, upper code 8, mode 7-6, lower 5-3, operand 2-0
// - layout three: target 10, pop 9, upper 8, mode 7-6 at 11, lower 5-3, slot 2-0
// - layout four: bits 10-8 are 001, 7-5 are 111, five-bit code
// - layout five: bits 10-8 are 011, 7-5 are 111, five-bit code
// - split code parts are joined into one operation code
// - format 00 real32, 01 int32, 10 real64, 11 int16
// - pop flag set means pop the stack after the operation
// - target bit selects stack top or the indexed slot as result
// - order bit xor target zero keeps destination then source
// - order bit xor target one swaps to source then destination
// - slot index counts from the stack top, 000 is top
module fed_escape_decoder
  import fed_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output fed_decode_s      decodeOut,
  output logic             decodeValid,
  output logic             foreignWord
);

  // ----------------------------------------------------------------
  // state of the whole block
  // ----------------------------------------------------------------
  typedef struct packed {
    fed_bus_e    busState;
    logic        waitReq;
    logic [31:0] readData;
    logic        enable;
    logic [15:0] word;
    fed_decode_s dec;
    logic        valid;
    logic        foreign;
    logic [15:0] acceptCount;
    logic [15:0] rejectCount;
  } fed_state_s;

  fed_state_s   state_q;
  fed_state_s   state_d;
  fed_avs_req_s req;
  logic [15:0]  mergedWord;
  fed_decode_s  mergedDec;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // byte-lane merge so a half written word keeps its other byte
  function automatic logic [15:0] mergeLanes(
    input logic [15:0] old,
    input logic [31:0] wdata,
    input logic [3:0]  be
  );
    logic [15:0] res;
    res       = old;
    if (be[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : mergeLanes

  // saturating counter step, one word wide enough for long runs
  function automatic logic [15:0] bumpCount(
    input logic [15:0] cnt
  );
    logic [15:0] res;
    res = (cnt == FED_COUNT_MAX) ? cnt : cnt + 16'h0001;
    return res;
  endfunction : bumpCount

  // ----------------------------------------------------------------
  // request bundle and incoming word
  // ----------------------------------------------------------------
  // bus inputs come from logic on sys_clk, so no synchroniser here
  assign req.read       = avs_read;
  assign req.write      = avs_write;
  assign req.address    = avs_address;
  assign req.writedata  = avs_writedata;
  assign req.byteenable = avs_byteenable;
  assign mergedWord     = mergeLanes(state_q.word, req.writedata, req.byteenable);

  // classifier sees the word as it will be stored
  fed_layout_decode u_layout (
    .word (mergedWord),
    .dec  (mergedDec)
  );

  // ----------------------------------------------------------------
  // read multiplexer
  // ----------------------------------------------------------------
  // unmapped offsets read as zero rather than bus error
  function automatic logic [31:0] readMux(
    input fed_state_s   s,
    input logic [3:0]   addr
  );
    logic [31:0] res;
    res = FED_READ_ZERO;
    case (addr)
      FED_OFF_CTRL: begin
        res[FED_CTRL_EN_BIT] = s.enable;
      end
      FED_OFF_WORD: begin
        res[15:0] = s.word;
      end
      FED_OFF_DECODE: begin
        res = s.dec;
      end
      FED_OFF_COUNT: begin
        res = {s.rejectCount, s.acceptCount};
      end
      default: begin
        res = FED_READ_ZERO;
      end
    endcase
    return res;
  endfunction : readMux

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // the slave answers one cycle after it first sees a request; the
  // fixed latency costs a cycle per access but keeps timing simple
  always_comb begin
    logic wordEvent;
    logic takeWrite;
    wordEvent       = 1'b0;
    takeWrite       = 1'b0;
    state_d         = state_q;
    state_d.valid   = 1'b0;
    state_d.foreign = 1'b0;
    state_d.waitReq = 1'b1;
    case (state_q.busState)
      FED_BUS_IDLE: begin
        if (req.read || req.write) begin
          state_d.busState = FED_BUS_ANSWER;
          state_d.waitReq  = 1'b0;
          state_d.readData = req.read ? readMux(state_q, req.address) : FED_READ_ZERO;
        end
      end
      FED_BUS_ANSWER: begin
        // the master samples waitrequest low on this edge
        state_d.busState = FED_BUS_IDLE;
        takeWrite        = req.write;
      end
      default: begin
        state_d.busState = FED_BUS_IDLE;
      end
    endcase

    // register writes land only on the completing edge
    if (takeWrite) begin
      case (req.address)
        FED_OFF_CTRL: begin
          if (req.byteenable[0]) begin
            state_d.enable = req.writedata[FED_CTRL_EN_BIT];
          end
        end
        FED_OFF_WORD: begin
          state_d.word = mergedWord;
          wordEvent    = state_q.enable;
        end
        FED_OFF_COUNT: begin
          state_d.acceptCount = FED_COUNT_RST;
          state_d.rejectCount = FED_COUNT_RST;
        end
        default: begin
          state_d.enable = state_q.enable;
        end
      endcase
    end

    // a disabled decoder stores the word but leaves the fields alone
    if (wordEvent) begin
      if (mergedDec.isCoproc) begin
        state_d.dec         = mergedDec;
        state_d.valid       = 1'b1;
        // count from the cleared value so a clear never eats an event
        state_d.acceptCount = bumpCount(state_d.acceptCount);
      end else begin
        // foreign words leave the last fields untouched
        state_d.foreign     = 1'b1;
        state_d.rejectCount = bumpCount(state_d.rejectCount);
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q.busState    <= FED_BUS_IDLE;
      state_q.waitReq     <= 1'b1;
      state_q.readData    <= FED_READ_ZERO;
      state_q.enable      <= FED_CTRL_RST;
      state_q.word        <= FED_WORD_RST;
      state_q.dec         <= '0;
      state_q.valid       <= 1'b0;
      state_q.foreign     <= 1'b0;
      state_q.acceptCount <= FED_COUNT_RST;
      state_q.rejectCount <= FED_COUNT_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  // memory forms expose only the mode and operand specifier; address
  // formation and any extension bytes stay with the host
  assign avs_readdata    = state_q.readData;
  assign avs_waitrequest = state_q.waitReq;
  assign decodeOut       = state_q.dec;
  assign decodeValid     = state_q.valid;
  assign foreignWord     = state_q.foreign;

endmodule : fed_escape_decoder
`default_nettype wire

// [core/fed_layout_decode.sv]
// combinational classifier that splits one escape word into its fields
`timescale 1ns/1ns
`default_nettype none
module fed_layout_decode
  import fed_pkg::*;
(
  input  wire logic [15:0] word,
  output fed_decode_s      dec
);

  // ----------------------------------------------------------------
  // layout selection and field extraction
  // ----------------------------------------------------------------
  // layouts four/five are tested first: their bits 7-6 are also 11 and
  // would otherwise be taken for stack forms
  always_comb begin
    dec                     = '0;
    dec.addressingKindField = word[7:6];
    dec.regMemField         = word[2:0];
    dec.stackSlotIndex      = word[2:0];
    dec.destSlot            = FED_SLOT_TOP;
    dec.memoryFormatField   = FED_MF_REAL32;
    if (word[FED_PREFIX_HI:FED_PREFIX_LO] != FED_PREFIX) begin
      dec.isCoproc = 1'b0;
      dec.layout   = FED_LAY_NONE;
    end else begin
      dec.isCoproc = 1'b1;
      if (word[7:5] == FED_NOARG_MID && (word[10:8] == FED_L4_HIGH || word[10:8] == FED_L5_HIGH)) begin
        dec.layout       = (word[10:8] == FED_L4_HIGH) ? FED_LAY_FOUR : FED_LAY_FIVE;
        dec.functionCode = word[4:0];
      end else if (word[7:6] == FED_KIND_REG) begin
        // register stack form
        dec.layout            = FED_LAY_THREE;
        dec.regStack          = 1'b1;
        dec.destToSlot        = word[10];
        dec.popStack          = word[9];
        dec.functionCodeUpper = {1'b0, word[8]};
        dec.functionCodeLower = word[5:3];
        dec.functionCode      = {1'b0, word[8], word[5:3]};
        dec.reverseOrder      = word[3] ^ word[10];
        dec.destSlot          = word[10] ? word[2:0] : FED_SLOT_TOP;
      end else if (word[8] && word[5]) begin
        dec.layout            = FED_LAY_ONE;
        dec.memOperand        = 1'b1;
        dec.functionCodeUpper = word[10:9];
        dec.functionCodeLower = {1'b0, word[4:3]};
        dec.functionCode      = {1'b0, word[10:9], word[4:3]};
      end else begin
        dec.layout            = FED_LAY_TWO;
        dec.memOperand        = 1'b1;
        dec.memoryFormatField = fed_memfmt_e'(word[10:9]);
        dec.functionCodeUpper = {1'b0, word[8]};
        dec.functionCodeLower = word[5:3];
        dec.functionCode      = {1'b0, word[8], word[5:3]};
      end
    end
  end

endmodule : fed_layout_decode
`default_nettype wire

// [inc/fed_pkg.sv]
// shared constants, types and register map of the escape-word decoder
package fed_pkg;

  // ----------------------------------------------------------------
  // instruction word layout
  // ----------------------------------------------------------------
  localparam int unsigned     FED_WORD_W      = 16;
  localparam logic [4:0]      FED_PREFIX      = 5'h1B;   // bits 15-11 of every coprocessor word
  localparam int unsigned     FED_PREFIX_HI   = 15;
  localparam int unsigned     FED_PREFIX_LO   = 11;
  localparam logic [1:0]      FED_KIND_REG    = 2'h3;    // addressing kind that names the stack
  localparam logic [2:0]      FED_L4_HIGH     = 3'h1;    // bits 10-8 of layout four
  localparam logic [2:0]      FED_L5_HIGH     = 3'h3;    // bits 10-8 of layout five
  localparam logic [2:0]      FED_NOARG_MID   = 3'h7;    // bits 7-5 of layouts four and five
  localparam logic [2:0]      FED_SLOT_TOP    = 3'h0;    // stack slot index of the stack top

  // ----------------------------------------------------------------
  // register map, byte addresses on the slave port
  // ----------------------------------------------------------------
  localparam int unsigned     FED_ADDR_W      = 4;
  localparam logic [3:0]      FED_OFF_CTRL    = 4'h0;
  localparam logic [3:0]      FED_OFF_WORD    = 4'h4;
  localparam logic [3:0]      FED_OFF_DECODE  = 4'h8;
  localparam logic [3:0]      FED_OFF_COUNT   = 4'hC;
  localparam int unsigned     FED_CTRL_EN_BIT = 0;
  localparam logic            FED_CTRL_RST    = 1'b1;    // decoder enabled after reset
  localparam logic [15:0]     FED_WORD_RST    = 16'h0000;
  localparam logic [15:0]     FED_COUNT_RST   = 16'h0000;
  localparam logic [15:0]     FED_COUNT_MAX   = 16'hFFFF;
  localparam logic [31:0]     FED_READ_ZERO   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FED_LAY_NONE  = 3'b000,
    FED_LAY_ONE   = 3'b001,
    FED_LAY_TWO   = 3'b010,
    FED_LAY_THREE = 3'b011,
    FED_LAY_FOUR  = 3'b100,
    FED_LAY_FIVE  = 3'b101
  } fed_layout_e;

  typedef enum logic [1:0] {
    FED_MF_REAL32 = 2'b00,
    FED_MF_INT32  = 2'b01,
    FED_MF_REAL64 = 2'b10,
    FED_MF_INT16  = 2'b11
  } fed_memfmt_e;

  typedef enum logic [0:0] {
    FED_BUS_IDLE   = 1'b0,
    FED_BUS_ANSWER = 1'b1
  } fed_bus_e;

  // ----------------------------------------------------------------
  // decoded fields, exactly one 32-bit word
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        isCoproc;
    fed_layout_e layout;
    logic        memOperand;
    logic        regStack;
    fed_memfmt_e memoryFormatField;
    logic [4:0]  functionCode;
    logic [1:0]  functionCodeUpper;
    logic [2:0]  functionCodeLower;
    logic [2:0]  stackSlotIndex;
    logic [1:0]  addressingKindField;
    logic [2:0]  regMemField;
    logic        popStack;
    logic        destToSlot;
    logic        reverseOrder;
    logic [2:0]  destSlot;
  } fed_decode_s;

  // avalon request as seen by the slave
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } fed_avs_req_s;

endpackage : fed_pkg

// [testbench/fed_escape_decoder_sva.sv]
// port checks of the escape-word decoder
`timescale 1ns/1ns
`default_nettype none
module fed_escape_decoder_sva
  import fed_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire fed_decode_s decodeOut,
  input wire logic        decodeValid,
  input wire logic        foreignWord
);
  logic        en_q;
  logic [15:0] w;
  logic        wordWr, okWord, noArg, layThree, layTwo;

  // a word write counts only when it completes while decoding is on
  assign w        = avs_writedata[15:0];
  assign wordWr   = avs_write && !avs_waitrequest && avs_address == FED_OFF_WORD && avs_byteenable[1:0] == 2'b11 && en_q;
  assign okWord   = wordWr && w[15:11] == FED_PREFIX;
  assign noArg    = w[7:5] == FED_NOARG_MID && (w[10:8] == FED_L4_HIGH || w[10:8] == FED_L5_HIGH);
  assign layThree = okWord && !noArg && w[7:6] == FED_KIND_REG;
  assign layTwo   = okWord && !noArg && w[7:6] != FED_KIND_REG && !(w[8] && w[5]);

  // shadow of the enable bit, since the checker cannot see the register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      en_q <= FED_CTRL_RST;
    end else if (avs_write && !avs_waitrequest && avs_address == FED_OFF_CTRL && avs_byteenable[0]) begin
      en_q <= avs_writedata[FED_CTRL_EN_BIT];
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_foreign_flagged: assert property (wordWr && w[15:11] != FED_PREFIX |=> foreignWord && !decodeValid && $stable(decodeOut))
    else $error("foreign word not flagged");
  a_prefix_taken: assert property (okWord |=> decodeValid && !foreignWord && decodeOut.isCoproc)
    else $error("prefixed word not accepted");
  a_no_cause: assert property (!wordWr |=> !decodeValid && !foreignWord)
    else $error("pulse without a word write");
  a_fields_stand: assert property (!$stable(decodeOut) |-> decodeValid)
    else $error("fields changed without a new word");
  a_layout_four: assert property (okWord && noArg && !w[9] |=> decodeOut.layout == FED_LAY_FOUR
    && decodeOut.functionCode == $past(avs_writedata[4:0]))
    else $error("layout four wrong");
  a_layout_five: assert property (okWord && noArg && w[9] |=> decodeOut.layout == FED_LAY_FIVE
    && decodeOut.functionCode == $past(avs_writedata[4:0]))
    else $error("layout five wrong");
  a_stack_form: assert property (layThree |=> decodeOut.layout == FED_LAY_THREE && decodeOut.regStack
    && decodeOut.popStack == $past(avs_writedata[9]) && decodeOut.destToSlot == $past(avs_writedata[10])
    && decodeOut.stackSlotIndex == $past(avs_writedata[2:0]))
    else $error("stack form fields wrong");
  a_order_swap: assert property (layThree |=> decodeOut.reverseOrder == ($past(avs_writedata[3]) ^ $past(avs_writedata[10])))
    else $error("operand order wrong");
  a_format_two: assert property (layTwo |=> decodeOut.layout == FED_LAY_TWO && !decodeOut.regStack
    && decodeOut.memoryFormatField == $past(avs_writedata[10:9]))
    else $error("memory format wrong");
endmodule : fed_escape_decoder_sva
bind fed_escape_decoder fed_escape_decoder_sva u_sva (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .decodeOut(decodeOut), .decodeValid(decodeValid), .foreignWord(foreignWord));
`default_nettype wire

// [testbench/fed_host_model.sv]
// host that forwards escape words over the register bus
`timescale 1ns/1ns
`default_nettype none
module fed_host_model
  import fed_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        avs_waitrequest,
  input  wire logic [31:0] avs_readdata,
  output logic      [3:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable
);
  // idle bus from time zero; all lanes on so words land whole
  initial begin
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end

  // only the word itself is forwarded: operand addresses and extension bytes stay with the host
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // released lines show garbage, never the old value
    avs_address   <= ~a;
    avs_writedata <= ~d;
  endtask : xfer
endmodule : fed_host_model
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench of the escape-word decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fed_pkg::*;
  typedef struct packed { logic foreign; fed_decode_s e; } fed_note_s;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest, decodeValid, foreignWord, en = 1'b1;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] acc = 16'h0000, frn = 16'h0000;
  fed_decode_s decodeOut, lastE;
  fed_note_s   notes[$], n;
  int          mismatches = 0, checked = 0, cycles = 0, i;

  always #4 sys_clk = ~sys_clk;

  fed_host_model host (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));
  fed_escape_decoder dut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .decodeOut(decodeOut),
    .decodeValid(decodeValid), .foreignWord(foreignWord));

  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (!ok) begin
      mismatches++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk

  // expected fields; only those that the word's layout defines are compared
  function automatic fed_decode_s mk(input logic [15:0] w);
    fed_decode_s e;
    e = '0;
    e.isCoproc = 1'b1;
    e.regStack = w[7:6] == FED_KIND_REG;
    e.functionCode = {1'b0, w[8], w[5:3]};
    e.functionCodeUpper = {1'b0, w[8]};
    e.functionCodeLower = w[5:3];
    e.memOperand = !e.regStack;
    e.addressingKindField = w[7:6];
    e.regMemField = w[2:0];
    e.popStack = w[9];
    e.destToSlot = w[10];
    e.stackSlotIndex = w[2:0];
    e.reverseOrder = w[3] ^ w[10];
    e.destSlot = w[10] ? w[2:0] : FED_SLOT_TOP;
    e.memoryFormatField = fed_memfmt_e'(w[10:9]);
    if (w[7:5] == FED_NOARG_MID && (w[10:8] == FED_L4_HIGH || w[10:8] == FED_L5_HIGH)) begin
      e.layout = w[9] ? FED_LAY_FIVE : FED_LAY_FOUR;
      e.functionCode = w[4:0];
    end else if (e.regStack) e.layout = FED_LAY_THREE;
    else if (w[8] && w[5]) begin
      e.layout = FED_LAY_ONE;
      e.functionCode = {1'b0, w[10:9], w[4:3]};
      e.functionCodeUpper = w[10:9];
      e.functionCodeLower = {1'b0, w[4:3]};
    end else e.layout = FED_LAY_TWO;
    return e;
  endfunction : mk

  task automatic cmp(input fed_decode_s e, input fed_decode_s g);
    chk(g.layout === e.layout && g.functionCode === e.functionCode && g.isCoproc === 1'b1, "layout or code");
    if (e.layout == FED_LAY_THREE) chk(g[5:0] === e[5:0] && g.stackSlotIndex === e.stackSlotIndex && g.regStack, "stack");
    // split code parts and operand kind only mean something outside layouts four and five
    if (e.layout != FED_LAY_FOUR && e.layout != FED_LAY_FIVE)
      chk(g[18:14] === e[18:14] && g.memOperand === e.memOperand, "split code");
    if (e.layout == FED_LAY_TWO) chk(g.memoryFormatField === e.memoryFormatField, "format");
    if (e.layout == FED_LAY_ONE || e.layout == FED_LAY_TWO) chk(g[10:6] === e[10:6] && !g.regStack, "operand");
  endtask : cmp

  task automatic get(input logic [3:0] a, input logic [31:0] x);
    host.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q === x, "register read");
  endtask : get

  // the note goes in before the word, the pulse follows one cycle after completion
  task automatic word(input logic [15:0] w);
    n.foreign = w[15:11] != FED_PREFIX;
    n.e = mk(w);
    if (en) begin
      notes.push_back(n);
      if (n.foreign) frn++;
      else begin
        acc++;
        lastE = n.e;
      end
    end
    host.xfer(1'b1, FED_OFF_WORD, {16'h0000, w}, q);
  endtask : word

  // watcher takes the oldest note for each pulse
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
    if (resetn === 1'b1 && (decodeValid === 1'b1 || foreignWord === 1'b1)) begin
      if (notes.size() == 0) chk(1'b0, "pulse with no word");
      else begin
        n = notes.pop_front();
        chk(foreignWord === n.foreign && decodeValid === !n.foreign, "pulse kind");
        if (!n.foreign) cmp(n.e, decodeOut);
      end
    end
  end

  // main sequence
  initial begin
    void'($urandom(95107));
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    get(FED_OFF_CTRL, 32'h0000_0001);
    get(FED_OFF_COUNT, 32'h0000_0000);
    get(4'h2, 32'h0000_0000);
    get(FED_OFF_DECODE, 32'h0000_0000);
    $display("test reset done");
    word(16'hD9E4);
    word(16'hDBE3);
    word({FED_PREFIX, 2'b10, 1'b1, 2'b01, 1'b1, 2'b11, 3'b110});
    for (i = 0; i < 4; i++) word({FED_PREFIX, i[1:0], 9'b0_0000_0101});
    for (i = 0; i < 8; i++) word({FED_PREFIX, i[1:0], 1'b1, 5'b11001, i[2:0]});
    word(16'h1234);
    host.xfer(1'b0, FED_OFF_DECODE, 32'h0000_0000, q);
    cmp(lastE, fed_decode_s'(q));
    $display("test layouts done");
    host.xfer(1'b1, FED_OFF_CTRL, 32'h0000_0000, q);
    en = 1'b0;
    word(16'hD9E4);
    word(16'h0F0F);
    get(FED_OFF_CTRL, 32'h0000_0000);
    host.xfer(1'b1, FED_OFF_CTRL, 32'h0000_0001, q);
    en = 1'b1;
    get(FED_OFF_COUNT, {frn, acc});
    host.xfer(1'b1, FED_OFF_COUNT, 32'h0000_0000, q);
    acc = 16'h0000;
    frn = 16'h0000;
    get(FED_OFF_COUNT, 32'h0000_0000);
    $display("test enable and counts done");
    for (i = 0; i < 60; i++) word(i[0] ? {FED_PREFIX, 11'($urandom)} : 16'($urandom));
    host.xfer(1'b0, FED_OFF_DECODE, 32'h0000_0000, q);
    cmp(lastE, fed_decode_s'(q));
    get(FED_OFF_COUNT, {frn, acc});
    repeat (3) @(posedge sys_clk);
    chk(notes.size() == 0, "missing pulses");
    $display("test random done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire
